// [rtl/cal_dac_pkg.sv]
// Purpose: constants and carrier types of the calibration DAC control register
// Assumes: 24-bit register words, 6-bit register addresses, core clock of 40 MHz
// Notes:   shared by the register block and whoever instantiates it
package cal_dac_pkg;

  localparam int unsigned        WORD_W       = 24;
  localparam int unsigned        ADDR_W       = 6;
  localparam int unsigned        CODE_W       = 10;
  localparam logic [ADDR_W-1:0]  CAL_ADDR     = 6'h09;
  localparam logic [WORD_W-1:0]  CAL_RESET    = 24'h002000;
  localparam logic [WORD_W-1:0]  CAL_WMASK    = 24'h003FFF;
  localparam int unsigned        CHOP_BIT     = 13;
  localparam int unsigned        MODE_BIT     = 12;
  localparam int unsigned        INT_BIT      = 11;
  localparam int unsigned        EN_BIT       = 10;
  localparam int unsigned        CODE_LSB     = 0;
  localparam int unsigned        RSVD_LSB     = 14;

  // timing
  localparam int unsigned        CLK_HZ       = 40000000;
  localparam int unsigned        CHOP_HZ      = 256000;
  localparam int unsigned        CHOP_HALF    = CLK_HZ / (2 * CHOP_HZ);
  localparam int unsigned        CHOP_CNT_W   = 7;
  localparam int unsigned        SCLK_TAIL    = 4;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } upd_state_e;

  typedef struct packed {
    logic              dac_power;
    logic              pin_connect;
    logic              internal_route;
    logic              ext_switch_open;
    logic              acq_enable;
    logic              ac_leadoff_off;
    logic              chop_clk;
    logic [CODE_W-1:0] dac_code;
  } cal_ctrl_s;

endpackage

// [rtl/cal_dac_ctrl.sv]
// Purpose: calibration DAC control register and the controls derived from it
// Assumes: register strobes come from the serial core on core_clk_i; sclk_i is the raw pin
// Notes:   a written word reaches the analog side only after four further serial clocks
`timescale 1ns/10ps

module cal_dac_ctrl #(
  parameter int unsigned TAIL_EDGES = cal_dac_pkg::SCLK_TAIL
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           wr_en_i,
  input  wire logic                           rd_en_i,
  input  wire logic [cal_dac_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [cal_dac_pkg::WORD_W-1:0] wdata_i,
  input  wire logic                           gang_slave_i,
  input  wire logic                           sclk_i,
  output logic      [cal_dac_pkg::WORD_W-1:0] rdata_o,
  output logic                                update_busy_o,
  output cal_dac_pkg::cal_ctrl_s              ctrl_o
);
  import cal_dac_pkg::*;

  // the tail counter is three bits wide
  if (TAIL_EDGES < 1 || TAIL_EDGES > 7) begin : g_tail_check
    $error("TAIL_EDGES must lie in 1..7");
  end

  // ----------------------------------------------------------------
  // register word and read port
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] cfg_q;
  logic [WORD_W-1:0] cfg_d;
  logic [WORD_W-1:0] rdata_q;
  logic [WORD_W-1:0] rdata_d;
  logic              wr_hit;

  assign wr_hit = wr_en_i && (addr_i == CAL_ADDR);

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = '0;
    if (wr_hit) begin
      cfg_d = wdata_i & CAL_WMASK;
    end
    if (rd_en_i && (addr_i == CAL_ADDR)) begin
      rdata_d = cfg_q & CAL_WMASK;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q   <= CAL_RESET;
      rdata_q <= '0;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // serial clock pin sampling
  // ----------------------------------------------------------------
  // third stage must agree with the second before a level counts
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic sclk_lvl_q;
  logic sclk_lvl_d;
  logic sclk_rise;

  always_comb begin
    sclk_lvl_d = sclk_lvl_q;
    if (sclk_s2_q == sclk_s3_q) begin
      sclk_lvl_d = sclk_s3_q;
    end
  end

  assign sclk_rise = sclk_lvl_d && !sclk_lvl_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_s1_q  <= 1'b0;
      sclk_s2_q  <= 1'b0;
      sclk_s3_q  <= 1'b0;
      sclk_lvl_q <= 1'b0;
    end else begin
      sclk_s1_q  <= sclk_i;
      sclk_s2_q  <= sclk_s1_q;
      sclk_s3_q  <= sclk_s2_q;
      sclk_lvl_q <= sclk_lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // deferred update of the applied word
  // ----------------------------------------------------------------
  // the analog side sees only the applied copy; a write during the wait restarts it
  upd_state_e       st_q;
  upd_state_e       st_d;
  logic [2:0]       edge_q;
  logic [2:0]       edge_d;
  logic [WORD_W-1:0] act_q;
  logic [WORD_W-1:0] act_d;

  always_comb begin
    st_d   = st_q;
    edge_d = edge_q;
    act_d  = act_q;
    case (st_q)
      ST_IDLE: begin
        if (wr_hit) begin
          st_d   = ST_WAIT;
          edge_d = '0;
        end
      end
      ST_WAIT: begin
        if (wr_hit) begin
          edge_d = '0;
        end else if (sclk_rise) begin
          if (edge_q == 3'(TAIL_EDGES - 1)) begin
            act_d = cfg_q;
            st_d  = ST_IDLE;
          end else begin
            edge_d = edge_q + 3'd1;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q   <= ST_IDLE;
      edge_q <= '0;
      act_q  <= CAL_RESET;
    end else begin
      st_q   <= st_d;
      edge_q <= edge_d;
      act_q  <= act_d;
    end
  end

  // ----------------------------------------------------------------
  // chop clock and derived controls
  // ----------------------------------------------------------------
  logic [CHOP_CNT_W-1:0] chop_cnt_q;
  logic [CHOP_CNT_W-1:0] chop_cnt_d;
  cal_ctrl_s             ctrl_q;
  cal_ctrl_s             ctrl_d;
  logic                  dac_on;

  // slave leaves its pin to the master's DAC
  assign dac_on = act_q[EN_BIT] && !gang_slave_i;

  always_comb begin
    chop_cnt_d = chop_cnt_q;
    ctrl_d     = ctrl_q;
    if (!act_q[CHOP_BIT]) begin
      chop_cnt_d       = '0;
      ctrl_d.chop_clk  = 1'b0;
    end else if (chop_cnt_q == CHOP_CNT_W'(CHOP_HALF - 1)) begin
      chop_cnt_d       = '0;
      ctrl_d.chop_clk  = !ctrl_q.chop_clk;
    end else begin
      chop_cnt_d       = chop_cnt_q + CHOP_CNT_W'(1);
    end
    ctrl_d.dac_power       = dac_on;
    ctrl_d.pin_connect     = act_q[MODE_BIT] || (dac_on && !act_q[MODE_BIT]);
    ctrl_d.internal_route  = act_q[MODE_BIT] && act_q[INT_BIT];
    ctrl_d.ext_switch_open = act_q[MODE_BIT] && act_q[INT_BIT];
    ctrl_d.acq_enable      = act_q[MODE_BIT];
    ctrl_d.ac_leadoff_off  = dac_on;
    ctrl_d.dac_code        = act_q[CODE_LSB +: CODE_W];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chop_cnt_q <= '0;
      ctrl_q     <= '0;
    end else begin
      chop_cnt_q <= chop_cnt_d;
      ctrl_q     <= ctrl_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      update_busy_o <= 1'b0;
    end else begin
      update_busy_o <= (st_d == ST_WAIT);
    end
  end

  assign rdata_o = rdata_q;
  assign ctrl_o  = ctrl_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_reset_word;
    $fell(rst_i) |-> (cfg_q == CAL_RESET) && (act_q == CAL_RESET);
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("reset word wrong");

  property p_chop_stops;
    !act_q[CHOP_BIT] |=> !ctrl_q.chop_clk;
  endproperty
  a_chop_stops: assert property (p_chop_stops) else $error("chop clock runs while off");

  property p_chop_half;
    $rose(ctrl_q.chop_clk) && act_q[CHOP_BIT] |-> ##78 !ctrl_q.chop_clk || !act_q[CHOP_BIT];
  endproperty
  a_chop_half: assert property (p_chop_half) else $error("chop half period wrong");

  property p_acq;
    1 |=> ctrl_q.acq_enable == $past(act_q[MODE_BIT]);
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition does not follow mode");

  property p_route;
    1 |=> (ctrl_q.internal_route == $past(act_q[MODE_BIT] && act_q[INT_BIT]))
          && (ctrl_q.ext_switch_open == ctrl_q.internal_route);
  endproperty
  a_route: assert property (p_route) else $error("internal route without open switches");

  property p_power;
    1 |=> ctrl_q.dac_power == $past(act_q[EN_BIT] && !gang_slave_i);
  endproperty
  a_power: assert property (p_power) else $error("dac power wrong for role");

  property p_pin;
    act_q[EN_BIT] && !gang_slave_i && !act_q[MODE_BIT] |=> ctrl_q.pin_connect;
  endproperty
  a_pin: assert property (p_pin) else $error("master pin not connected");

  property p_leadoff;
    act_q[EN_BIT] && !gang_slave_i |=> ctrl_q.ac_leadoff_off;
  endproperty
  a_leadoff: assert property (p_leadoff) else $error("ac lead-off left on");

  sequence s_last_edge;
    (st_q == ST_WAIT) && !wr_hit && sclk_rise && (edge_q == 3'(TAIL_EDGES - 1));
  endsequence
  property p_apply;
    s_last_edge |=> (act_q == $past(cfg_q)) ##1 (ctrl_q.dac_code == act_q[CODE_W-1:0]);
  endproperty
  a_apply: assert property (p_apply) else $error("update not applied after tail clocks");

  property p_hold;
    (st_q == ST_WAIT) && !sclk_rise |=> $stable(act_q);
  endproperty
  a_hold: assert property (p_hold) else $error("applied word changed early");

  property p_rsvd;
    rdata_q[WORD_W-1:RSVD_LSB] == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

endmodule

// [verification/host_sclk_model.sv]
// Purpose: host side serial clock source for the update tail
// Assumes: bench calls burst from its own clocked sequence
// Notes:   sclk stands still low outside bursts, like a real idle master
`timescale 1ns/10ps
module host_sclk_model (
  input  wire logic core_clk_i,
  output logic      sclk_o
);
  // ------------------
  // serial clock burst
  // ------------------
  initial sclk_o = 1'b0;
  // four cycles per phase so the pin filter sees every rise
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      #2 sclk_o = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #2 sclk_o = 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
    #2;
  endtask
endmodule

// [verification/calibration_dac_control_bench.sv]
// Purpose: self-checking bench of the calibration DAC control register
// Assumes: default tail of four serial clocks
// Notes:   each scenario judges its own results
`timescale 1ns/10ps
module calibration_dac_control_bench;
  import cal_dac_pkg::*;
  logic              core_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wr_en_i = 1'b0;
  logic              rd_en_i = 1'b0;
  logic              gang_slave_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [WORD_W-1:0] wdata_i = '0;
  logic [WORD_W-1:0] rdata_o;
  logic [WORD_W-1:0] q;
  logic              update_busy_o;
  logic              sclk_i;
  cal_ctrl_s         ctrl_o;
  int                err_total = 0;
  int                checks = 0;
  int                n;
  always #12.5 core_clk_i = ~core_clk_i;
  host_sclk_model host (.core_clk_i(core_clk_i), .sclk_o(sclk_i));
  cal_dac_ctrl dut (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .wr_en_i      (wr_en_i),
    .rd_en_i      (rd_en_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .gang_slave_i (gang_slave_i),
    .sclk_i       (sclk_i),
    .rdata_o      (rdata_o),
    .update_busy_o(update_busy_o),
    .ctrl_o       (ctrl_o)
  );
  // ----------------
  // shared helpers
  // ----------------
  task automatic cmp(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge core_clk_i);
    #2;
  endtask
  // one access; read data is taken one cycle after the request edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    step(1);
    wr_en_i = wr;
    rd_en_i = !wr;
    addr_i = a;
    wdata_i = d;
    step(1);
    wr_en_i = 1'b0;
    rd_en_i = 1'b0;
    q = rdata_o;
  endtask
  task automatic wait_idle();
    n = 0;
    while (update_busy_o !== 1'b0 && n < 60) begin
      step(1);
      n++;
    end
    if (n == 60) begin
      err_total++;
      complete_run();
    end else begin
      step(2);
    end
  endtask
  // cycles until chop clock flips, 200 if it never does; must makes 200 a timeout
  task automatic wait_flip(input bit must);
    logic c;
    c = ctrl_o.chop_clk;
    n = 0;
    while (ctrl_o.chop_clk === c && n < 200) begin
      step(1);
      n++;
    end
    if (must && n == 200) begin
      err_total++;
      complete_run();
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    bus(1'b0, CAL_ADDR, '0);
    cmp(q, 24'h002000);
    cmp(ctrl_o.dac_code, 10'h000);
    cmp(ctrl_o[16:11], 6'h00);
    bus(1'b0, 6'h0A, '0);
    cmp(q, 24'h000000);
    wait_flip(1'b1);
    wait_flip(1'b1);
    cmp(n, CHOP_HALF);
  endtask
  task automatic t_internal();
    bus(1'b1, CAL_ADDR, 24'hFFDC55);
    bus(1'b0, CAL_ADDR, '0);
    cmp(q, 24'h001C55);
    cmp(update_busy_o, 1'b1);
    cmp(ctrl_o.dac_code, 10'h000);
    host.burst(4);
    wait_idle();
    cmp(ctrl_o[16:11], 6'h3F);
    cmp(ctrl_o.dac_code, 10'h055);
    wait_flip(1'b0);
    cmp(n, 200);
  endtask
  task automatic t_slave();
    gang_slave_i = 1'b1;
    step(2);
    cmp(ctrl_o.dac_power, 1'b0);
    cmp(ctrl_o.ac_leadoff_off, 1'b0);
    cmp(ctrl_o.pin_connect, 1'b1);
    gang_slave_i = 1'b0;
    step(2);
    cmp(ctrl_o.dac_power, 1'b1);
  endtask
  task automatic t_external();
    bus(1'b1, CAL_ADDR, 24'h000400);
    host.burst(3);
    step(20);
    cmp(update_busy_o, 1'b1);
    cmp(ctrl_o.acq_enable, 1'b1);
    host.burst(1);
    wait_idle();
    cmp(ctrl_o[16:11], 6'h31);
  endtask
  // reset in mid-run drops a pending word
  task automatic t_midreset();
    bus(1'b1, CAL_ADDR, 24'h000155);
    rst_i = 1'b1;
    step(2);
    rst_i = 1'b0;
    cmp(update_busy_o, 1'b0);
    bus(1'b0, CAL_ADDR, '0);
    cmp(q, 24'h002000);
    cmp(ctrl_o, 17'h00000);
  endtask
  initial begin
    step(3);
    rst_i = 1'b0;
    t_reset();
    t_internal();
    t_slave();
    t_external();
    t_midreset();
    complete_run();
  end
endmodule
